// >>> hdl/wake_cfg_pkg.sv
package wake_cfg_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [6:0]  ADDR_WAKE_CTRL       = 7'h30;
    localparam logic [6:0]  ADDR_WAKE_BIT_TIMING = 7'h31;
    localparam logic [6:0]  ADDR_WAKE_IDENT_HIGH = 7'h32;
    localparam logic [6:0]  ADDR_WAKE_IDENT_LOW  = 7'h33;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int          SAMPLE_MSB     = 15;
    localparam int          SAMPLE_LSB     = 10;
    localparam int          QPB_MSB        = 7;
    localparam int          QPB_LSB        = 0;
    localparam int          IDL_HI_MSB     = 15;
    localparam int          IDL_HI_LSB     = 8;
    localparam int          IDL_RSVD_BIT   = 7;
    localparam int          IDL_LO_MSB     = 6;
    localparam int          IDL_LO_LSB     = 2;
    localparam int          IDL_RTR_BIT    = 1;
    localparam int          IDL_IDE_BIT    = 0;
    localparam int          CTRL_VALID_BIT = 0;
    localparam int          STD_ID_LSB     = 18;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] BIT_TIMING_RESET = 16'hcc96;
    localparam logic [15:0] IDENT_RESET      = 16'h0000;
    localparam logic [15:0] READ_ZERO        = 16'h0000;
    localparam logic [5:0]  SAMPLE_RESET     = BIT_TIMING_RESET[SAMPLE_MSB:SAMPLE_LSB];
    localparam logic [7:0]  QPB_RESET        = BIT_TIMING_RESET[QPB_MSB:QPB_LSB];

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [28:0] ident;
        logic        rtr;
        logic        ide;
    } rx_frame_t;

    typedef struct packed {
        logic [5:0]  sample_point_fraction;
        logic [7:0]  quanta_per_bit;
        logic [28:0] ident;
        logic        rtr;
        logic        ide;
        logic        wake_config_valid;
        logic [15:0] rdata;
        logic        rvalid;
        logic        wake_frame_match;
    } cfg_state_t;

endpackage

// >>> hdl/can_wake_frame_id_config.sv
`timescale 1ns/1ns
module can_wake_frame_id_config
    import wake_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Reset kinds besides power-on
    input  wire logic        soft_reset,
    input  wire logic        restart,
    // Register access from the serial interface decoder
    input  wire reg_req_t    req,
    output logic [15:0]      rdata,
    output logic             rvalid,
    // Frame checking
    input  wire logic        wake_event,
    input  wire logic [28:0] ident_compare_select,
    input  wire rx_frame_t   rx_frame,
    output logic             wake_frame_match,
    // Configuration to the bit sampler
    output logic [5:0]       sample_point_fraction,
    output logic [7:0]       quanta_per_bit,
    output logic             wake_config_valid
);

    cfg_state_t st_r;
    cfg_state_t st_nxt;
    logic       cfg_write;
    logic       id_hit;
    logic       rd_req;

    // ----------------------------------------------------------------
    // Read image of each register
    // ----------------------------------------------------------------
    function automatic logic [15:0] read_image(input cfg_state_t s, input logic [6:0] a);
        logic [15:0] v;
        v = READ_ZERO;
        if (a == ADDR_WAKE_BIT_TIMING)
        begin
            v[SAMPLE_MSB:SAMPLE_LSB] = s.sample_point_fraction;
            v[QPB_MSB:QPB_LSB] = s.quanta_per_bit;
        end
        else if (a == ADDR_WAKE_IDENT_HIGH)
        begin
            v = s.ident[28:13];
        end
        else if (a == ADDR_WAKE_IDENT_LOW)
        begin
            v[IDL_HI_MSB:IDL_HI_LSB] = s.ident[12:5];
            v[IDL_LO_MSB:IDL_LO_LSB] = s.ident[4:0];
            v[IDL_RTR_BIT]           = s.rtr;
            v[IDL_IDE_BIT]           = s.ide;
        end
        else if (a == ADDR_WAKE_CTRL)
        begin
            v[CTRL_VALID_BIT] = s.wake_config_valid;
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Frame comparison
    // ----------------------------------------------------------------
    // A standard frame carries only identifier bits 28..18, so the lower bits never take part.
    always_comb
    begin
        id_hit = 1'b1;
        for (int i = 0; i < 29; i++)
        begin
            if (ident_compare_select[i] && (st_r.ide || i >= STD_ID_LSB) &&
                (rx_frame.ident[i] != st_r.ident[i]))
            begin
                id_hit = 1'b0;
            end
        end
    end

    assign cfg_write = req.wr && (req.addr == ADDR_WAKE_BIT_TIMING || req.addr == ADDR_WAKE_IDENT_HIGH ||
                                  req.addr == ADDR_WAKE_IDENT_LOW);
    assign rd_req    = req.rd && !req.wr;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.rvalid = rd_req;
        if (rd_req)
        begin
            st_nxt.rdata = read_image(st_r, req.addr);
        end
        st_nxt.wake_frame_match = rx_frame.valid && st_r.wake_config_valid && id_hit &&
                                  (rx_frame.rtr == st_r.rtr) && (rx_frame.ide == st_r.ide);
        if (soft_reset)
        begin
            st_nxt.sample_point_fraction = SAMPLE_RESET;
            st_nxt.quanta_per_bit        = QPB_RESET;
            st_nxt.ident                 = {IDENT_RESET, IDENT_RESET[12:0]};
            st_nxt.rtr                   = IDENT_RESET[IDL_RTR_BIT];
            st_nxt.ide                   = IDENT_RESET[IDL_IDE_BIT];
            st_nxt.wake_config_valid     = 1'b0;
            st_nxt.wake_frame_match      = 1'b0;
        end
        else if (restart)
        begin
            // Reserved bits are not stored, so they stay cleared; everything stored is kept except rvalid and wake_frame_match, which clear.
            st_nxt = st_r;
            st_nxt.rvalid = 1'b0;
            st_nxt.wake_frame_match = 1'b0;
        end
        else
        begin
            if (req.wr && req.addr == ADDR_WAKE_BIT_TIMING)
            begin
                st_nxt.sample_point_fraction = req.wdata[SAMPLE_MSB:SAMPLE_LSB];
                st_nxt.quanta_per_bit        = req.wdata[QPB_MSB:QPB_LSB];
            end
            else if (req.wr && req.addr == ADDR_WAKE_IDENT_HIGH)
            begin
                st_nxt.ident[28:13] = req.wdata;
            end
            else if (req.wr && req.addr == ADDR_WAKE_IDENT_LOW)
            begin
                st_nxt.ident[12:5] = req.wdata[IDL_HI_MSB:IDL_HI_LSB];
                st_nxt.ident[4:0]  = req.wdata[IDL_LO_MSB:IDL_LO_LSB];
                st_nxt.rtr         = req.wdata[IDL_RTR_BIT];
                st_nxt.ide         = req.wdata[IDL_IDE_BIT];
            end
            // The controller's own set wins over a clear in the same cycle, so a fresh
            // validation is never lost to a coincident wake.
            if (wake_event || cfg_write)
            begin
                st_nxt.wake_config_valid = 1'b0;
            end
            if (req.wr && req.addr == ADDR_WAKE_CTRL)
            begin
                st_nxt.wake_config_valid = req.wdata[CTRL_VALID_BIT] || (st_r.wake_config_valid &&
                                           !wake_event);
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r                       <= '0;
            st_r.sample_point_fraction <= SAMPLE_RESET;
            st_r.quanta_per_bit        <= QPB_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdata                 = st_r.rdata;
    assign rvalid                = st_r.rvalid;
    assign wake_frame_match      = st_r.wake_frame_match;
    assign sample_point_fraction = st_r.sample_point_fraction;
    assign quanta_per_bit        = st_r.quanta_per_bit;
    assign wake_config_valid     = st_r.wake_config_valid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    AST_SAMPLE_WRITE: assert property (req.wr && req.addr == ADDR_WAKE_BIT_TIMING && !soft_reset && !restart
        |=> sample_point_fraction == $past(req.wdata[SAMPLE_MSB:SAMPLE_LSB])) else $error("sample point not stored");
    AST_QPB_READ: assert property (rd_req && req.addr == ADDR_WAKE_BIT_TIMING && !soft_reset && !restart
        |=> rdata[QPB_MSB:QPB_LSB] == quanta_per_bit) else $error("quanta readback wrong");
    AST_RSVD_ZERO: assert property (rvalid && $past(req.addr) == ADDR_WAKE_BIT_TIMING
        |-> rdata[9:8] == 2'b00) else $error("timing reserved bits not zero");
    AST_LOW_RSVD: assert property (rd_req && req.addr == ADDR_WAKE_IDENT_LOW
        |=> !rdata[IDL_RSVD_BIT]) else $error("low reserved bit not zero");
    AST_HIGH_MAP: assert property (rd_req && req.addr == ADDR_WAKE_IDENT_HIGH && !soft_reset && !restart
        |=> rdata == st_r.ident[28:13]) else $error("high identifier map wrong");
    AST_LOW_MAP: assert property (req.wr && req.addr == ADDR_WAKE_IDENT_LOW && !soft_reset && !restart
        ##1 rd_req && req.addr == ADDR_WAKE_IDENT_LOW && !req.wr
        |=> rdata == ($past(req.wdata, 2) & 16'hff7f)) else $error("low identifier roundtrip wrong");
    AST_SOFT_RESET: assert property (soft_reset
        |=> quanta_per_bit == QPB_RESET && sample_point_fraction == SAMPLE_RESET && st_r.ident == '0)
        else $error("soft reset values wrong");
    AST_RESTART_KEEP: assert property (restart && !soft_reset
        |=> $stable(st_r.ident) && $stable(quanta_per_bit)) else $error("restart changed configuration");
    AST_VALID_CLEAR: assert property (cfg_write && !restart && !(req.wr && req.addr == ADDR_WAKE_CTRL)
        |=> !wake_config_valid) else $error("config change left valid set");
    AST_NO_MATCH: assert property (!wake_config_valid |=> !wake_frame_match)
        else $error("match while not valid");

    COV_MATCH: cover property (wake_frame_match);
    COV_VALID_WAKE: cover property (wake_config_valid ##1 wake_event ##1 !wake_config_valid);
    COV_RESTART: cover property (restart ##1 rd_req);
    COV_SOFT_READ: cover property (soft_reset ##1 rd_req);
    COV_STD_MATCH: cover property (wake_frame_match && !st_r.ide);

    // ----------------------------------------------------------------
    // Field checks
    // ----------------------------------------------------------------
    // Each stored field is checked on its own, so a swapped slice shows up at once.

    AST_QPB_WRITE: assert property (
        req.wr && req.addr == ADDR_WAKE_BIT_TIMING && !soft_reset && !restart
        |=> quanta_per_bit == $past(req.wdata[QPB_MSB:QPB_LSB]))
        else $error("quanta per bit not stored");

    AST_HIGH_WRITE: assert property (
        req.wr && req.addr == ADDR_WAKE_IDENT_HIGH && !soft_reset && !restart
        |=> st_r.ident[28:13] == $past(req.wdata))
        else $error("high identifier not stored");

    AST_LOW_HI_FIELD: assert property (
        req.wr && req.addr == ADDR_WAKE_IDENT_LOW && !soft_reset && !restart
        |=> st_r.ident[12:5] == $past(req.wdata[IDL_HI_MSB:IDL_HI_LSB]))
        else $error("identifier bits 12 to 5 not stored");

    AST_LOW_LO_FIELD: assert property (
        req.wr && req.addr == ADDR_WAKE_IDENT_LOW && !soft_reset && !restart
        |=> st_r.ident[4:0] == $past(req.wdata[IDL_LO_MSB:IDL_LO_LSB]))
        else $error("identifier bits 4 to 0 not stored");

    AST_RTR_FIELD: assert property (
        req.wr && req.addr == ADDR_WAKE_IDENT_LOW && !soft_reset && !restart
        |=> st_r.rtr == $past(req.wdata[IDL_RTR_BIT]))
        else $error("frame type bit not stored");

    AST_IDE_FIELD: assert property (
        req.wr && req.addr == ADDR_WAKE_IDENT_LOW && !soft_reset && !restart
        |=> st_r.ide == $past(req.wdata[IDL_IDE_BIT]))
        else $error("identifier format bit not stored");

    AST_CTRL_RSVD: assert property (
        rvalid && $past(req.addr) == ADDR_WAKE_CTRL
        |-> rdata[15:1] == 15'h0000)
        else $error("control reserved bits not zero");

    AST_UNMAPPED_READ: assert property (
        rd_req && !restart && (req.addr < ADDR_WAKE_CTRL || req.addr > ADDR_WAKE_IDENT_LOW)
        |=> rdata == READ_ZERO)
        else $error("unmapped read not zero");

    AST_SOFT_LOW: assert property (
        soft_reset
        |=> !st_r.rtr && !st_r.ide && !wake_config_valid)
        else $error("soft reset left low identifier or valid set");

    AST_RESTART_TIMING: assert property (
        restart && !soft_reset
        |=> $stable(sample_point_fraction) && $stable(quanta_per_bit))
        else $error("restart changed bit timing");

    AST_RESTART_LOW: assert property (
        restart && !soft_reset
        |=> $stable(st_r.ident[12:0]) && $stable(st_r.rtr) && $stable(st_r.ide))
        else $error("restart changed low identifier");

    AST_VALID_SET: assert property (
        req.wr && req.addr == ADDR_WAKE_CTRL && req.wdata[CTRL_VALID_BIT] && !soft_reset && !restart
        |=> wake_config_valid)
        else $error("valid flag not set");

    AST_WAKE_CLEAR: assert property (
        wake_event && !restart && !(req.wr && req.addr == ADDR_WAKE_CTRL)
        |=> !wake_config_valid)
        else $error("wake left valid set");

    AST_MASK_MISS: assert property (
        rx_frame.valid && st_r.ide && ident_compare_select[0] && (rx_frame.ident[0] != st_r.ident[0])
        |=> !wake_frame_match)
        else $error("masked bit mismatch still matched");

    AST_RTR_MISS: assert property (
        rx_frame.valid && (rx_frame.rtr != st_r.rtr)
        |=> !wake_frame_match)
        else $error("frame type mismatch still matched");

    AST_MATCH_PULSE: assert property (
        wake_frame_match
        |-> $past(rx_frame.valid))
        else $error("match without a frame");

endmodule // can_wake_frame_id_config

// >>> tb/can_node_model.sv
`timescale 1ns/1ns
// --------------------------------
// Remote node sending wake frames
// --------------------------------
module can_node_model
    import wake_cfg_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Received frame towards the matcher
    output rx_frame_t rx_frame
);
    // Fields are inverted between frames, so a stale identifier cannot match by luck.
    initial rx_frame = '0;
    task automatic send(input logic [28:0] ident, input logic rtr, input logic ide);
        @(negedge core_clk);
        rx_frame = '{valid: 1'b1, ident: ident, rtr: rtr, ide: ide};
        @(negedge core_clk);
        rx_frame = '{valid: 1'b0, ident: ~ident, rtr: ~rtr, ide: ~ide};
    endtask
endmodule // can_node_model

// >>> tb/can_wake_frame_id_config_tb_top.sv
`timescale 1ns/1ns
module can_wake_frame_id_config_tb_top
    import wake_cfg_pkg::*;
;
    localparam logic [28:0] WID = {16'ha5c3, 8'h5a, 5'b11101};
    logic        core_clk   = 1'b0;
    logic        rst_b      = 1'b0;
    logic        soft_reset = 1'b0;
    logic        restart    = 1'b0;
    logic        wake_event = 1'b0;
    logic [28:0] mask       = '1;
    reg_req_t    req        = '0;
    rx_frame_t   rx_frame;
    logic [15:0] rdata;
    logic        rvalid;
    logic        match;
    logic [5:0]  spf;
    logic [7:0]  qpb;
    logic        cfg_valid;
    int          err_count  = 0;
    int          num_checks = 0;

    always #5 core_clk = ~core_clk;

    can_node_model node_u (.core_clk(core_clk), .rx_frame(rx_frame));

    can_wake_frame_id_config dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .soft_reset(soft_reset), .restart(restart),
        .req(req), .rdata(rdata), .rvalid(rvalid), .wake_event(wake_event),
        .ident_compare_select(mask), .rx_frame(rx_frame), .wake_frame_match(match),
        .sample_point_fraction(spf), .quanta_per_bit(qpb), .wake_config_valid(cfg_valid)
    );

    // --------------------------------
    // Access and compare tasks
    // --------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [6:0] addr, input logic [15:0] data);
        @(negedge core_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge core_clk);
        req = '0;
    endtask

    // Read data is registered at the taking edge, so it is sampled half a cycle later at the next falling edge.
    task automatic reg_read(input logic [6:0] addr, input logic [15:0] exp);
        @(negedge core_clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
        @(negedge core_clk);
        req = '0;
        check({15'h0000, rvalid}, 16'h0001);
        check(rdata, exp);
    endtask

    task automatic frame(input logic [28:0] id, input logic rtr, input logic ide, input logic exp);
        node_u.send(id, rtr, ide);
        check({15'h0000, match}, {15'h0000, exp});
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        err_count++;
        give_verdict();
    end

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial
    begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) rst_b = 1'b1;
        check({10'h000, spf}, 16'h0033);
        check({8'h00, qpb}, 16'h0096);
        reg_read(ADDR_WAKE_BIT_TIMING, 16'hcc96);
        reg_read(ADDR_WAKE_IDENT_HIGH, 16'h0000);
        reg_read(ADDR_WAKE_IDENT_LOW, 16'h0000);
        reg_write(ADDR_WAKE_BIT_TIMING, 16'hffff);
        reg_read(ADDR_WAKE_BIT_TIMING, 16'hfcff);
        check({10'h000, spf}, 16'h003f);
        check({8'h00, qpb}, 16'h00ff);
        reg_write(ADDR_WAKE_IDENT_HIGH, 16'ha5c3);
        reg_write(ADDR_WAKE_IDENT_LOW, 16'hffff);
        reg_read(ADDR_WAKE_IDENT_LOW, 16'hff7f);
        reg_write(ADDR_WAKE_IDENT_LOW, 16'h5a75);
        // Write then read in back-to-back cycles.
        @(negedge core_clk) req = '{wr: 1'b1, rd: 1'b0, addr: ADDR_WAKE_IDENT_LOW, wdata: 16'h5a75};
        @(negedge core_clk) req = '{wr: 1'b0, rd: 1'b1, addr: ADDR_WAKE_IDENT_LOW, wdata: 16'h0000};
        @(negedge core_clk) req = '0;
        check(rdata, 16'h5a75);
        reg_read(7'h34, 16'h0000);
        @(negedge core_clk) restart = 1'b1;
        @(negedge core_clk) restart = 1'b0;
        reg_read(ADDR_WAKE_BIT_TIMING, 16'hfcff);
        reg_read(ADDR_WAKE_IDENT_HIGH, 16'ha5c3);
        reg_read(ADDR_WAKE_IDENT_LOW, 16'h5a75);
        reg_write(ADDR_WAKE_CTRL, 16'hffff);
        reg_read(ADDR_WAKE_CTRL, 16'h0001);
        frame(WID, 1'b0, 1'b1, 1'b1);
        frame(WID ^ 29'h1000_0000, 1'b0, 1'b1, 1'b0);
        frame(WID ^ 29'h0000_1000, 1'b0, 1'b1, 1'b0);
        frame(WID ^ 29'h0000_0001, 1'b0, 1'b1, 1'b0);
        frame(WID, 1'b1, 1'b1, 1'b0);
        frame(WID, 1'b0, 1'b0, 1'b0);
        mask = ~29'h0000_0001;
        frame(WID ^ 29'h0000_0001, 1'b0, 1'b1, 1'b1);
        mask = '1;
        // A standard identifier compares only the top eleven bits.
        reg_write(ADDR_WAKE_IDENT_LOW, 16'h5a74);
        check({15'h0000, cfg_valid}, 16'h0000);
        reg_write(ADDR_WAKE_CTRL, 16'h0001);
        frame(WID ^ 29'h0000_0001, 1'b0, 1'b0, 1'b1);
        @(negedge core_clk) wake_event = 1'b1;
        @(negedge core_clk) wake_event = 1'b0;
        check({15'h0000, cfg_valid}, 16'h0000);
        frame(WID, 1'b0, 1'b0, 1'b0);
        @(negedge core_clk) soft_reset = 1'b1;
        @(negedge core_clk) soft_reset = 1'b0;
        reg_read(ADDR_WAKE_BIT_TIMING, 16'hcc96);
        reg_read(ADDR_WAKE_IDENT_HIGH, 16'h0000);
        reg_read(ADDR_WAKE_IDENT_LOW, 16'h0000);
        give_verdict();
    end
endmodule // can_wake_frame_id_config_tb_top
